// file: hw/srcl_loader.sv
// Purpose: loads the configuration header image from serial rom, serves config reads
// Assumes: rom byte reader answers each request with one valid pulse; apb slave
// Notes:   config port answers one cycle after a request is taken
//
// Function
// [R01] after reset fetch image 00h-2Fh from rom before header is used
// [R02] rom byte 0Ch loads bits 7:0 of base address 1
// [R03] rom bytes 0Dh-0Fh load bits 31:8 of base address 1
// [R04] rom bytes 10h-13h load base address 2, low byte first
// [R05] rom bytes 14h-17h load base address 3, low byte first
// [R06] rom bytes 18h-1Bh load base address 4, low byte first
// [R07] rom byte 00h equal 00h: bytes 1Ch-1Fh load base address 5
// [R08] rom byte 00h equal 01h: bytes 1Ch-1Fh load base address 0
// [R09] rom bytes 20h/21h form subsystem vendor id at 2Ch
// [R10] rom bytes 22h/23h form subsystem id at 2Eh
// [R11] rom bytes 24h-27h form expansion rom base at 30h
// [R12] capabilities pointer at 34h comes from rom byte 28h
// [R13] three capabilities: ids 01h, 03h and 06h
// [R14] capabilities placed at 40h, 48h and 50h
// [R15] pointer 00h hides all three capabilities
// [R16] power management next pointer comes from rom byte 29h
// [R17] vpd next pointer comes from rom byte 2Fh
// [R18] hot swap next pointer is fixed zero
// [R19] rom byte 2Ah bits 6:5 give data scale in power management status 14:13
// [R20] data select 0h returns rom byte 2Bh at 47h
// [R21] data select 3h, 4h, 7h return rom bytes 2Ch, 2Dh, 2Eh
// [R22] rom programmer writes zero into reserved bytes from 30h
// [R23] read rom ascending after reset; retry config accesses until loaded
// [R24] other data select values return zero
`timescale 1ns/10ps
`default_nettype none

module srcl_loader (
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    input  wire srcl_pkg::srcl_cfg_req_s cfg_req,
    output var  logic                   cfg_ack,
    output var  logic                   cfg_retry,
    output var  logic [31:0]            cfg_rdata,
    output var  logic                   rom_rd_req,
    output var  logic [5:0]             rom_addr,
    input  wire srcl_pkg::srcl_rom_rsp_s rom_rsp,
    output var  logic                   load_done,
    input  wire logic [11:0]            paddr,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output var  logic [31:0]            prdata,
    output var  logic                   pready,
    output var  logic                   pslverr
);
    import srcl_pkg::*;

    // ****************************************
    // state
    // ****************************************
    srcl_state_e state_r;
    logic [7:0]  img_r [SRCL_IMG_BYTES];
    logic [5:0]  addr_r;
    logic        done_r;
    logic        reload_r;
    logic [1:0]  pstate_r;
    logic [3:0]  dsel_r;
    logic [31:0] rd_word;
    logic        cfg_take;
    logic        apb_hit;

    function automatic logic [31:0] img_word(input logic [5:0] base);
        img_word = {img_r[base + 6'h3], img_r[base + 6'h2],
                    img_r[base + 6'h1], img_r[base]};
    endfunction

    // ****************************************
    // rom fetch sequencer
    // ****************************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= SRCL_IDLE;
            addr_r  <= 6'h00;
            done_r  <= 1'b0;
        end else begin
            unique case (state_r)
                SRCL_IDLE: begin
                    addr_r  <= 6'h00;
                    state_r <= SRCL_REQ; // R01
                end
                SRCL_REQ: begin
                    state_r <= SRCL_WAIT;
                end
                SRCL_WAIT: begin
                    if (rom_rsp.valid) begin
                        if (addr_r == SRCL_IMG_LAST) begin
                            done_r  <= 1'b1; // R01
                            state_r <= SRCL_DONE;
                        end else begin
                            addr_r  <= addr_r + 6'h01; // R23
                            state_r <= SRCL_REQ;
                        end
                    end
                end
                SRCL_DONE: begin
                    // a reload re-runs the whole fetch; config answers retry meanwhile
                    if (reload_r) begin
                        done_r  <= 1'b0;
                        state_r <= SRCL_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rom_rd_req <= 1'b0;
            rom_addr   <= 6'h00;
        end else begin
            rom_rd_req <= (state_r == SRCL_REQ);
            rom_addr   <= addr_r;
        end
    end

    // image bytes land in order; all rom-loaded header fields decode from this copy
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < SRCL_IMG_BYTES; i++) begin
                img_r[i] <= 8'h00;
            end
        end else if (state_r == SRCL_WAIT && rom_rsp.valid) begin
            img_r[addr_r] <= rom_rsp.data; // R01
        end
    end

    // ****************************************
    // configuration header read decode
    // ****************************************
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (cfg_req.idx)
            SRCL_CFG_BAR0: begin
                if (img_r[SRCL_ROM_SEL] == SRCL_SEL_BAR0) begin
                    rd_word = img_word(SRCL_ROM_BAR50); // R08
                end
            end
            SRCL_CFG_BAR1: rd_word = img_word(SRCL_ROM_BAR1); // R02 R03
            SRCL_CFG_BAR2: rd_word = img_word(SRCL_ROM_BAR2); // R04
            SRCL_CFG_BAR3: rd_word = img_word(SRCL_ROM_BAR3); // R05
            SRCL_CFG_BAR4: rd_word = img_word(SRCL_ROM_BAR4); // R06
            SRCL_CFG_BAR5: begin
                if (img_r[SRCL_ROM_SEL] == SRCL_SEL_BAR5) begin
                    rd_word = img_word(SRCL_ROM_BAR50); // R07
                end
            end
            SRCL_CFG_SUBS: begin
                rd_word = {img_r[SRCL_ROM_SID + 6'h1], img_r[SRCL_ROM_SID], // R10
                           img_r[SRCL_ROM_SVID + 6'h1], img_r[SRCL_ROM_SVID]}; // R09
            end
            SRCL_CFG_XPROM: rd_word = img_word(SRCL_ROM_XPROM); // R11
            SRCL_CFG_CAPP:  rd_word = {24'h00_0000, img_r[SRCL_ROM_CAPP]}; // R12
            SRCL_CFG_PM0: begin
                rd_word = {SRCL_PM_CAPS, img_r[SRCL_ROM_PMNXT], SRCL_CAPID_PM}; // R13 R14 R16
            end
            SRCL_CFG_PMCTL: begin
                rd_word = {pm_data(dsel_r), 8'h00, 1'b0,
                           img_r[SRCL_ROM_SCALE][6:5], dsel_r, 7'h00, pstate_r}; // R19
            end
            SRCL_CFG_VPD0: begin
                rd_word = {16'h0000, img_r[SRCL_ROM_VPNXT], SRCL_CAPID_VPD}; // R13 R14 R17
            end
            SRCL_CFG_HS: begin
                rd_word = {16'h0000, SRCL_HS_NEXT, SRCL_CAPID_HS}; // R13 R14 R18
            end
            default: rd_word = 32'h0000_0000;
        endcase
        // with no list head the capability block reads as empty space
        if (img_r[SRCL_ROM_CAPP] == 8'h00 && cfg_req.idx >= SRCL_CFG_PM0
                && cfg_req.idx <= SRCL_CFG_HS) begin
            rd_word = 32'h0000_0000; // R15
        end
    end

    function automatic logic [7:0] pm_data(input logic [3:0] sel);
        unique case (sel)
            SRCL_DSEL_D0: pm_data = img_r[SRCL_ROM_D0]; // R20
            SRCL_DSEL_D3: pm_data = img_r[SRCL_ROM_D3]; // R21
            SRCL_DSEL_D4: pm_data = img_r[SRCL_ROM_D4]; // R21
            SRCL_DSEL_D7: pm_data = img_r[SRCL_ROM_D7]; // R21
            default:      pm_data = 8'h00; // R24
        endcase
    endfunction

    // ****************************************
    // configuration access port
    // ****************************************
    // one answer per request: no new take while an answer pulse is out
    assign cfg_take = cfg_req.valid && !cfg_ack && !cfg_retry;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_ack   <= 1'b0;
            cfg_retry <= 1'b0;
            cfg_rdata <= 32'h0000_0000;
        end else begin
            cfg_ack   <= cfg_take && done_r;
            cfg_retry <= cfg_take && !done_r; // R23
            if (cfg_take && done_r && !cfg_req.wr) begin
                cfg_rdata <= rd_word;
            end
        end
    end

    // only the power state and data select fields take host writes
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pstate_r <= SRCL_PSTATE_RST;
            dsel_r   <= SRCL_DSEL_RST;
        end else if (cfg_take && done_r && cfg_req.wr && cfg_req.idx == SRCL_CFG_PMCTL
                     && img_r[SRCL_ROM_CAPP] != 8'h00) begin
            if (cfg_req.be[0]) begin
                pstate_r <= cfg_req.wdata[1:0];
            end
            if (cfg_req.be[1]) begin
                dsel_r <= cfg_req.wdata[12:9];
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            load_done <= 1'b0;
        end else begin
            load_done <= done_r;
        end
    end

    // ****************************************
    // apb slave
    // ****************************************
    // one wait state: pready rises in the second access cycle
    assign apb_hit = psel && penable && pready;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && penable && !pready) begin
                unique case (paddr)
                    SRCL_APB_CTRL: prdata <= 32'h0000_0000;
                    SRCL_APB_STAT: prdata <= {16'h0000, 2'b00, addr_r, 6'h00,
                                              (state_r != SRCL_DONE), done_r};
                    default:       pslverr <= 1'b1;
                endcase
            end
        end
    end

    // reload is a self-clearing command, seen only once loading is over
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reload_r <= 1'b0;
        end else begin
            reload_r <= apb_hit && pwrite && paddr == SRCL_APB_CTRL && pstrb[0]
                        && pwdata[SRCL_CTRL_RELOAD];
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    logic [5:0] last_req_r;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            last_req_r <= 6'h00;
        end else if (rom_rd_req) begin
            last_req_r <= rom_addr;
        end
    end

    property p_retry_loading;
        cfg_take && !done_r |=> cfg_retry && !cfg_ack;
    endproperty
    a_retry_loading: assert property (p_retry_loading) else $error("no retry while loading"); // R23

    property p_ascending;
        rom_rd_req && rom_addr != 6'h00 |-> rom_addr == last_req_r + 6'h01;
    endproperty
    a_ascending: assert property (p_ascending) else $error("rom not read in order"); // R23

    property p_done_after_last;
        state_r == SRCL_WAIT && rom_rsp.valid && addr_r == SRCL_IMG_LAST
            |=> done_r ##1 load_done;
    endproperty
    a_done_after_last: assert property (p_done_after_last) else $error("load did not end"); // R01

    property p_bar1;
        cfg_take && done_r && !cfg_req.wr && cfg_req.idx == SRCL_CFG_BAR1
            |=> cfg_ack && cfg_rdata == {img_r[6'h0f], img_r[6'h0e], img_r[6'h0d], img_r[6'h0c]};
    endproperty
    a_bar1: assert property (p_bar1) else $error("bar1 mismatch"); // R03

    property p_bar5;
        cfg_take && done_r && !cfg_req.wr && cfg_req.idx == SRCL_CFG_BAR5
            && img_r[6'h00] == 8'h00 |=> cfg_rdata[7:0] == img_r[6'h1c];
    endproperty
    a_bar5: assert property (p_bar5) else $error("bar5 mismatch"); // R07

    property p_bar0;
        cfg_take && done_r && !cfg_req.wr && cfg_req.idx == SRCL_CFG_BAR0
            && img_r[6'h00] == 8'h01 |=> cfg_rdata[31:24] == img_r[6'h1f];
    endproperty
    a_bar0: assert property (p_bar0) else $error("bar0 mismatch"); // R08

    property p_caps_hidden;
        cfg_take && done_r && !cfg_req.wr && img_r[6'h28] == 8'h00
            && cfg_req.idx == SRCL_CFG_PM0 |=> cfg_rdata == 32'h0000_0000;
    endproperty
    a_caps_hidden: assert property (p_caps_hidden) else $error("caps not hidden"); // R15

    property p_hs_next;
        cfg_take && done_r && !cfg_req.wr && cfg_req.idx == SRCL_CFG_HS
            |=> cfg_rdata[15:8] == 8'h00;
    endproperty
    a_hs_next: assert property (p_hs_next) else $error("hot swap next not zero"); // R18

    property p_scale;
        cfg_take && done_r && !cfg_req.wr && cfg_req.idx == SRCL_CFG_PMCTL
            && img_r[6'h28] != 8'h00 |=> cfg_rdata[14:13] == img_r[6'h2a][6:5];
    endproperty
    a_scale: assert property (p_scale) else $error("data scale mismatch"); // R19

    property p_data_other;
        cfg_take && done_r && !cfg_req.wr && cfg_req.idx == SRCL_CFG_PMCTL
            && !(dsel_r inside {4'h0, 4'h3, 4'h4, 4'h7}) |=> cfg_rdata[31:24] == 8'h00;
    endproperty
    a_data_other: assert property (p_data_other) else $error("unused data select nonzero"); // R24

    property p_data_d0;
        cfg_take && done_r && !cfg_req.wr && cfg_req.idx == SRCL_CFG_PMCTL
            && img_r[6'h28] != 8'h00 && dsel_r == 4'h0 |=> cfg_rdata[31:24] == img_r[6'h2b];
    endproperty
    a_data_d0: assert property (p_data_d0) else $error("d0 data mismatch"); // R20

    property p_cov_load;
        state_r == SRCL_WAIT ##1 state_r == SRCL_DONE;
    endproperty
    c_cov_load: cover property (p_cov_load);

    property p_cov_retry;
        cfg_retry;
    endproperty
    c_cov_retry: cover property (p_cov_retry);

    property p_cov_reload;
        reload_r && state_r == SRCL_DONE;
    endproperty
    c_cov_reload: cover property (p_cov_reload);

    property p_cov_pmw;
        cfg_take && done_r && cfg_req.wr && cfg_req.idx == SRCL_CFG_PMCTL;
    endproperty
    c_cov_pmw: cover property (p_cov_pmw);

endmodule

`default_nettype wire

// file: hw/srcl_pkg.sv
// Purpose: constants and types for the serial rom configuration header loader
// Assumes: 48-byte configuration image, byte addressed rom, dword config indices
// Notes:   config offsets are held as dword indices (byte offset / 4)
`default_nettype none
package srcl_pkg;

    // ****************************************
    // image layout in the serial rom
    // ****************************************
    localparam int       SRCL_IMG_BYTES = 48;
    localparam logic [5:0] SRCL_IMG_LAST  = 6'h2f;
    localparam logic [5:0] SRCL_ROM_SEL   = 6'h00;
    localparam logic [5:0] SRCL_ROM_BAR1  = 6'h0c;
    localparam logic [5:0] SRCL_ROM_BAR2  = 6'h10;
    localparam logic [5:0] SRCL_ROM_BAR3  = 6'h14;
    localparam logic [5:0] SRCL_ROM_BAR4  = 6'h18;
    localparam logic [5:0] SRCL_ROM_BAR50 = 6'h1c;
    localparam logic [5:0] SRCL_ROM_SVID  = 6'h20;
    localparam logic [5:0] SRCL_ROM_SID   = 6'h22;
    localparam logic [5:0] SRCL_ROM_XPROM = 6'h24;
    localparam logic [5:0] SRCL_ROM_CAPP  = 6'h28;
    localparam logic [5:0] SRCL_ROM_PMNXT = 6'h29;
    localparam logic [5:0] SRCL_ROM_SCALE = 6'h2a;
    localparam logic [5:0] SRCL_ROM_D0    = 6'h2b;
    localparam logic [5:0] SRCL_ROM_D3    = 6'h2c;
    localparam logic [5:0] SRCL_ROM_D4    = 6'h2d;
    localparam logic [5:0] SRCL_ROM_D7    = 6'h2e;
    localparam logic [5:0] SRCL_ROM_VPNXT = 6'h2f;
    localparam logic [7:0] SRCL_SEL_BAR5  = 8'h00;
    localparam logic [7:0] SRCL_SEL_BAR0  = 8'h01;

    // ****************************************
    // configuration header, dword indices
    // ****************************************
    localparam logic [5:0] SRCL_CFG_BAR0  = 6'h04;
    localparam logic [5:0] SRCL_CFG_BAR1  = 6'h05;
    localparam logic [5:0] SRCL_CFG_BAR2  = 6'h06;
    localparam logic [5:0] SRCL_CFG_BAR3  = 6'h07;
    localparam logic [5:0] SRCL_CFG_BAR4  = 6'h08;
    localparam logic [5:0] SRCL_CFG_BAR5  = 6'h09;
    localparam logic [5:0] SRCL_CFG_SUBS  = 6'h0b;
    localparam logic [5:0] SRCL_CFG_XPROM = 6'h0c;
    localparam logic [5:0] SRCL_CFG_CAPP  = 6'h0d;
    localparam logic [5:0] SRCL_CFG_PM0   = 6'h10;
    localparam logic [5:0] SRCL_CFG_PMCTL = 6'h11;
    localparam logic [5:0] SRCL_CFG_VPD0  = 6'h12;
    localparam logic [5:0] SRCL_CFG_VPD1  = 6'h13;
    localparam logic [5:0] SRCL_CFG_HS    = 6'h14;
    localparam logic [7:0] SRCL_CAPID_PM  = 8'h01;
    localparam logic [7:0] SRCL_CAPID_VPD = 8'h03;
    localparam logic [7:0] SRCL_CAPID_HS  = 8'h06;
    localparam logic [7:0] SRCL_HS_NEXT   = 8'h00;
    localparam logic [15:0] SRCL_PM_CAPS  = 16'h0000;
    localparam logic [3:0] SRCL_DSEL_D0   = 4'h0;
    localparam logic [3:0] SRCL_DSEL_D3   = 4'h3;
    localparam logic [3:0] SRCL_DSEL_D4   = 4'h4;
    localparam logic [3:0] SRCL_DSEL_D7   = 4'h7;
    localparam logic [1:0] SRCL_PSTATE_RST = 2'h0;
    localparam logic [3:0] SRCL_DSEL_RST  = 4'h0;

    // ****************************************
    // apb register map
    // ****************************************
    localparam logic [11:0] SRCL_APB_CTRL = 12'h000;
    localparam logic [11:0] SRCL_APB_STAT = 12'h004;
    localparam int          SRCL_CTRL_RELOAD = 0;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [3:0] {
        SRCL_IDLE = 4'h1,
        SRCL_REQ  = 4'h2,
        SRCL_WAIT = 4'h4,
        SRCL_DONE = 4'h8
    } srcl_state_e;

    typedef struct packed {
        logic        valid;
        logic        wr;
        logic [5:0]  idx;
        logic [3:0]  be;
        logic [31:0] wdata;
    } srcl_cfg_req_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } srcl_rom_rsp_s;

endpackage

`default_nettype wire

// file: sim/srcl_rom_model.sv
// Purpose: behavioural serial rom answering the loader byte requests
// Assumes: one request outstanding; answer after 1 idle cycle, or 4 when slow
// Notes:   data shows the inverse of the last byte outside the valid pulse
`timescale 1ns/10ps
`default_nettype none

module srcl_rom_model (
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    input  wire logic                    rom_rd_req,
    input  wire logic [5:0]              rom_addr,
    input  wire logic                    slow,
    output var  srcl_pkg::srcl_rom_rsp_s rom_rsp
);
    import srcl_pkg::*;

    // ****************************************
    // byte store and answer timing
    // ****************************************
    logic [7:0] mem [128];
    logic [7:0] last_r;
    logic [5:0] addr_r;
    int         wait_r;

    // reserved bytes from 30h stay zero
    initial foreach (mem[i]) mem[i] = 8'h00;

    // stale data is never repeated, so a late sample cannot pass by luck
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wait_r  <= 0;
            last_r  <= 8'h00;
            addr_r  <= 6'h00;
            rom_rsp <= '0;
        end else begin
            rom_rsp.valid <= 1'b0;
            rom_rsp.data  <= ~last_r;
            if (rom_rd_req) begin
                addr_r <= rom_addr;
                wait_r <= slow ? 4 : 1;
            end else if (wait_r == 1) begin
                rom_rsp.valid <= 1'b1;
                rom_rsp.data  <= mem[addr_r];
                last_r        <= mem[addr_r];
                wait_r        <= 0;
            end else if (wait_r > 1) begin
                wait_r <= wait_r - 1;
            end
        end
    end
endmodule

`default_nettype wire

// file: sim/tb_top.sv
// Purpose: self-checking bench for the configuration header loader
// Assumes: rom model prompt on first load, slow on reload
// Notes:   images drawn from an lfsr seeded with 34
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    import srcl_pkg::*;

    // ****************************************
    // stimulus, instances and checks
    // ****************************************
    logic          clk = 1'b0;
    logic          sys_rst = 1'b1;
    srcl_cfg_req_s cfg_req = '0;
    srcl_rom_rsp_s rom_rsp;
    logic          cfg_ack, cfg_retry, load_done, rom_rd_req, pready, pslverr;
    logic [31:0]   cfg_rdata, prdata;
    logic [5:0]    rom_addr;
    logic [11:0]   paddr = 12'h000;
    logic          psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
    logic [31:0]   pwdata = 32'h0, exp_addr = 32'h0;
    logic [3:0]    pstrb = 4'hf;
    logic [7:0]    img [48];
    logic [7:0]    seed = 8'h22;
    int            num_errors = 0, cmp_count = 0;

    always #2.5 clk = ~clk;

    srcl_loader dut_u (
        .clk(clk), .sys_rst(sys_rst), .cfg_req(cfg_req), .cfg_ack(cfg_ack),
        .cfg_retry(cfg_retry), .cfg_rdata(cfg_rdata), .rom_rd_req(rom_rd_req),
        .rom_addr(rom_addr), .rom_rsp(rom_rsp), .load_done(load_done),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr)
    );

    srcl_rom_model rom_u (
        .clk(clk), .sys_rst(sys_rst), .rom_rd_req(rom_rd_req),
        .rom_addr(rom_addr), .slow(slow), .rom_rsp(rom_rsp)
    );

    task automatic conclude();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    function automatic logic [7:0] rnd();
        seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
        return seed;
    endfunction

    function automatic logic [31:0] rw(input int a);
        return {img[a+3], img[a+2], img[a+1], img[a]};
    endfunction

    function automatic logic [31:0] exp_cfg(input logic [5:0] i, input logic [3:0] ds,
                                            input logic [1:0] ps);
        logic [7:0]  d;
        logic [31:0] v;
        case (ds)
            4'h0:    d = img[6'h2b];
            4'h3:    d = img[6'h2c];
            4'h4:    d = img[6'h2d];
            4'h7:    d = img[6'h2e];
            default: d = 8'h00;
        endcase
        case (i)
            6'h04:   v = (img[0] == 8'h01) ? rw(6'h1c) : 32'h0;
            6'h05:   v = rw(6'h0c);
            6'h06:   v = rw(6'h10);
            6'h07:   v = rw(6'h14);
            6'h08:   v = rw(6'h18);
            6'h09:   v = (img[0] == 8'h00) ? rw(6'h1c) : 32'h0;
            6'h0b:   v = rw(6'h20);
            6'h0c:   v = rw(6'h24);
            6'h0d:   v = {24'h0, img[6'h28]};
            6'h10:   v = {16'h0, img[6'h29], 8'h01};
            6'h11:   v = {d, 9'h0, img[6'h2a][6:5], ds, 7'h0, ps};
            6'h12:   v = {16'h0, img[6'h2f], 8'h03};
            6'h14:   v = 32'h6;
            default: v = 32'h0;
        endcase
        if (i >= 6'h10 && img[6'h28] == 8'h00) v = 32'h0;
        return v;
    endfunction

    task automatic cfg(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
                       output logic ok, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        cfg_req <= {1'b1, wr, idx, 4'h3, wd};
        do begin
            @(posedge clk);
            n++;
        end while (cfg_ack !== 1'b1 && cfg_retry !== 1'b1 && n < 50);
        cfg_req <= '0;
        ok = cfg_ack;
        rd = cfg_rdata;
        if (n >= 50) num_errors++;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) num_errors++;
    endtask

    task automatic wait_done(input logic lvl);
        int n;
        n = 0;
        while (load_done !== lvl && n < 5000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 5000) num_errors++;
    endtask

    task automatic make_image(input logic [7:0] sel, input logic [7:0] capp);
        foreach (img[i]) img[i] = rnd();
        img[0] = sel;
        img[6'h28] = capp;
        img[6'h29] = 8'h48;
        img[6'h2f] = 8'h50;
        // only the four legal scale codes
        img[6'h2a] = img[6'h2a] & 8'h60;
        foreach (img[i]) rom_u.mem[i] = img[i];
    endtask

    task automatic check_all();
        logic        ok;
        logic [31:0] rd;
        for (int i = 4; i <= 20; i++) begin
            cfg(1'b0, i[5:0], 32'h0, ok, rd);
            chk_word("cfg_ack", 32'h1, {31'h0, ok});
            chk_word("cfg_rdata", exp_cfg(i[5:0], 4'h0, 2'h0), rd);
        end
    endtask

    always @(posedge clk) begin
        if (rom_rd_req === 1'b1) begin
            chk_word("rom_addr", exp_addr, {26'h0, rom_addr});
            exp_addr++;
        end
    end

    initial begin
        #100000;
        num_errors++;
        conclude();
    end

    initial begin
        logic        ok;
        logic        err;
        logic [7:0]  rb;
        logic [31:0] rd;
        @(posedge clk);
        make_image(8'h00, 8'h40);
        repeat (7) @(posedge clk);
        sys_rst <= 1'b0;
        cfg(1'b0, 6'h05, 32'h0, ok, rd);
        chk_word("cfg_ack", 32'h0, {31'h0, ok});
        wait_done(1'b1);
        chk_word("rom_count", 32'h30, exp_addr);
        apb(1'b0, 12'h004, 32'h0, rd, err);
        chk_word("status_done", 32'h1, {31'h0, rd[0]});
        apb(1'b0, 12'h008, 32'h0, rd, err);
        chk_word("pslverr", 32'h1, {31'h0, err});
        check_all();
        for (int d = 0; d < 16; d++) begin
            rb = rnd();
            cfg(1'b1, 6'h11, {19'h0, d[3:0], 7'h0, rb[1:0]}, ok, rd);
            cfg(1'b0, 6'h11, 32'h0, ok, rd);
            chk_word("pm_data", exp_cfg(6'h11, d[3:0], rb[1:0]), rd);
        end
        make_image(8'h01, 8'h00);
        slow <= 1'b1;
        exp_addr = 32'h0;
        apb(1'b1, 12'h000, 32'h1, rd, err);
        wait_done(1'b0);
        wait_done(1'b1);
        chk_word("rom_count", 32'h30, exp_addr);
        check_all();
        conclude();
    end
endmodule

`default_nettype wire
